// >>> logic/cmb_pkg.sv
/*
  Shared constants and types for the core memory bus interface: bus widths,
  access sizes, memory map windows and the flash control register offsets.
  Assumes a single 50 MHz clock shared by core, memories and peripherals.
*/
// Notes on behaviour
// - program memory returns 16-bit words on fetch
// - program writes use low 16 write bits
// - program address 21 bits, data on read bus
// - primary data reads/writes are 32 bits
// - primary address supports byte, word, long
// - primary address also selects peripheral registers
// - secondary bus: words only, 16-bit read
// - peripheral bus same clock, no waits
// - peripheral writes/reads use primary data buses
// - byte access forces address msb low
// - primary RAM 32 wide, others 16
// - flash control via peripheral bus registers
`default_nettype none
package cmb_pkg;
  localparam int PAW = 21;
  localparam int DAW = 24;
  localparam int PDW = 16;
  localparam int XDW = 32;
  localparam int PRW = 16;
  // ---------------------------------------------------------------
  // memory map (word addresses)
  // ---------------------------------------------------------------
  localparam int PMEM_WORDS = 1024;
  localparam int DMEM_LONGS = 1024;
  localparam int PMEM_AW = 10;
  localparam int DMEM_AW = 11;
  localparam logic [DAW-1:0] PERIPH_BASE = 24'hFFF000;
  localparam logic [DAW-1:0] PERIPH_MASK = 24'hFFF000;
  localparam int PERIPH_REGS = 16;
  localparam int PERIPH_AW = 4;
  localparam logic [PERIPH_AW-1:0] FLASH_CMD_IDX = 4'h0;
  localparam logic [PERIPH_AW-1:0] FLASH_STAT_IDX = 4'h1;
  localparam logic [PRW-1:0] FLASH_STAT_RST = 16'h0001;
  typedef enum logic [1:0] {
    CMB_SZ_BYTE = 2'b00,
    CMB_SZ_WORD = 2'b01,
    CMB_SZ_LONG = 2'b11
  } cmb_size_e;
endpackage : cmb_pkg
`default_nettype wire

// >>> logic/cmb_if.sv
/*
  Carrier between the core end and the memory/peripheral end.
  Assumes both ends share clk; no clocking block.
*/
`default_nettype none
interface cmb_if;
  logic [cmb_pkg::PAW-1:0] prog_address_bus;
  logic prog_rd;
  logic prog_wr;
  logic [cmb_pkg::PDW-1:0] prog_read_bus;
  logic [cmb_pkg::DAW-1:0] primary_data_address_bus;
  logic pri_rd;
  logic pri_wr;
  cmb_pkg::cmb_size_e pri_size;
  logic [cmb_pkg::XDW-1:0] pri_write_bus;
  logic [cmb_pkg::XDW-1:0] pri_read_bus;
  logic [cmb_pkg::DAW-1:0] secondary_data_address_bus;
  logic sec_rd;
  logic [cmb_pkg::PDW-1:0] secondary_read_bus;
  modport core (output prog_address_bus, prog_rd, prog_wr, primary_data_address_bus,
    pri_rd, pri_wr, pri_size, pri_write_bus, secondary_data_address_bus, sec_rd,
    input prog_read_bus, pri_read_bus, secondary_read_bus);
  modport mem (input prog_address_bus, prog_rd, prog_wr, primary_data_address_bus,
    pri_rd, pri_wr, pri_size, pri_write_bus, secondary_data_address_bus, sec_rd,
    output prog_read_bus, pri_read_bus, secondary_read_bus);
endinterface : cmb_if
`default_nettype wire

// >>> logic/cmb_core_end.sv
/*
  Core end: registers core requests onto the system buses and returns read
  data three cycles after the request. Assumes the memory end answers in one cycle.
*/
`default_nettype none
module cmb_core_end (
  input wire logic clk,
  input wire logic rst,
  cmb_if.core bus,
  input wire logic req_prog_rd,
  input wire logic req_prog_wr,
  input wire logic [cmb_pkg::PAW-1:0] req_prog_addr,
  input wire logic req_pri_rd,
  input wire logic req_pri_wr,
  input wire cmb_pkg::cmb_size_e req_pri_size,
  input wire logic [cmb_pkg::DAW-1:0] req_pri_addr,
  input wire logic [cmb_pkg::XDW-1:0] req_pri_wdata,
  input wire logic req_sec_rd,
  input wire logic [cmb_pkg::DAW-1:0] req_sec_addr,
  output logic [cmb_pkg::PDW-1:0] prog_rdata,
  output logic prog_rvalid,
  output logic [cmb_pkg::XDW-1:0] pri_rdata,
  output logic pri_rvalid,
  output logic [cmb_pkg::PDW-1:0] sec_rdata,
  output logic sec_rvalid
);
  logic prog_pend_reg;
  logic pri_pend_reg;
  logic sec_pend_reg;
  // ---------------------------------------------------------------
  // request drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.prog_rd <= 1'b0;
      bus.prog_wr <= 1'b0;
      bus.prog_address_bus <= '0;
      bus.pri_rd <= 1'b0;
      bus.pri_wr <= 1'b0;
      bus.pri_size <= cmb_pkg::CMB_SZ_WORD;
      bus.primary_data_address_bus <= '0;
      bus.pri_write_bus <= '0;
      bus.sec_rd <= 1'b0;
      bus.secondary_data_address_bus <= '0;
    end else begin
      bus.prog_rd <= req_prog_rd;
      bus.prog_wr <= req_prog_wr;
      bus.prog_address_bus <= req_prog_addr;
      bus.pri_rd <= req_pri_rd;
      bus.pri_wr <= req_pri_wr;
      bus.pri_size <= req_pri_size;
      // byte accesses stay in the lower half, so the msb leaves the core low for them
      bus.primary_data_address_bus <= {req_pri_addr[cmb_pkg::DAW-1]
        && (req_pri_size != cmb_pkg::CMB_SZ_BYTE), req_pri_addr[cmb_pkg::DAW-2:0]};
      bus.pri_write_bus <= req_pri_wdata;
      // secondary is independent of primary so both issue together
      bus.sec_rd <= req_sec_rd;
      bus.secondary_data_address_bus <= req_sec_addr;
    end
  end
  // ---------------------------------------------------------------
  // read return
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_pend_reg <= 1'b0;
      pri_pend_reg <= 1'b0;
      sec_pend_reg <= 1'b0;
      prog_rvalid <= 1'b0;
      pri_rvalid <= 1'b0;
      sec_rvalid <= 1'b0;
      prog_rdata <= '0;
      pri_rdata <= '0;
      sec_rdata <= '0;
    end else begin
      prog_pend_reg <= bus.prog_rd;
      pri_pend_reg <= bus.pri_rd;
      sec_pend_reg <= bus.sec_rd;
      prog_rvalid <= prog_pend_reg;
      pri_rvalid <= pri_pend_reg;
      sec_rvalid <= sec_pend_reg;
      if (prog_pend_reg) begin
        prog_rdata <= bus.prog_read_bus;
      end
      if (pri_pend_reg) begin
        pri_rdata <= bus.pri_read_bus;
      end
      if (sec_pend_reg) begin
        sec_rdata <= bus.secondary_read_bus;
      end
    end
  end
endmodule : cmb_core_end
`default_nettype wire

// >>> logic/cmb_mem_end.sv
/*
  Memory end: program RAM, 32-bit primary data RAM with a 16-bit secondary
  read port, and a zero-wait peripheral register window holding the flash
  control registers. Assumes the core end holds each request for one cycle;
  reads answer on the cycle after the request.
*/
`default_nettype none
module cmb_mem_end (
  input wire logic clk,
  input wire logic rst,
  cmb_if.mem bus,
  output logic [cmb_pkg::PRW-1:0] flash_cmd,
  output logic flash_cmd_strobe,
  input wire logic [cmb_pkg::PRW-1:0] flash_status
);
  logic [cmb_pkg::PDW-1:0] prog_mem [cmb_pkg::PMEM_WORDS];
  logic [cmb_pkg::XDW-1:0] data_mem [cmb_pkg::DMEM_LONGS];
  logic [cmb_pkg::PRW-1:0] periph_reg [cmb_pkg::PERIPH_REGS];
  logic [cmb_pkg::DAW-1:0] pri_addr;
  logic pri_is_periph;
  logic [cmb_pkg::DMEM_AW-1:0] pri_word;
  logic [cmb_pkg::DMEM_AW-1:0] sec_word;
  logic [cmb_pkg::PERIPH_AW-1:0] periph_idx;
  logic [cmb_pkg::PMEM_AW-1:0] prog_idx;
  logic [cmb_pkg::XDW-1:0] lane_mask;
  logic [cmb_pkg::XDW-1:0] lane_data;
  logic [cmb_pkg::PRW-1:0] flash_stat_reg;

  function automatic logic is_periph(input logic [cmb_pkg::DAW-1:0] a);
    return (a & cmb_pkg::PERIPH_MASK) == cmb_pkg::PERIPH_BASE;
  endfunction

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    pri_addr = bus.primary_data_address_bus;
    // byte accesses live in the lower half only
    if (bus.pri_size == cmb_pkg::CMB_SZ_BYTE) begin
      pri_addr[cmb_pkg::DAW-1] = 1'b0;
    end
  end
  assign pri_is_periph = is_periph(pri_addr);
  assign periph_idx = pri_addr[cmb_pkg::PERIPH_AW-1:0];
  // primary address counts 16-bit words; two per 32-bit line
  assign pri_word = pri_addr[cmb_pkg::DMEM_AW-1:0];
  assign sec_word = bus.secondary_data_address_bus[cmb_pkg::DMEM_AW-1:0];
  assign prog_idx = bus.prog_address_bus[cmb_pkg::PMEM_AW-1:0];

  always_comb begin
    lane_mask = '0;
    lane_data = bus.pri_write_bus;
    case (bus.pri_size)
      cmb_pkg::CMB_SZ_BYTE: begin
        lane_mask = {{(cmb_pkg::XDW-8){1'b0}}, 8'hFF} << (pri_word[0] ? cmb_pkg::PDW : 0);
        lane_data = bus.pri_write_bus << (pri_word[0] ? cmb_pkg::PDW : 0);
      end
      cmb_pkg::CMB_SZ_WORD: begin
        lane_mask = {{(cmb_pkg::XDW-16){1'b0}}, 16'hFFFF} << (pri_word[0] ? cmb_pkg::PDW : 0);
        lane_data = bus.pri_write_bus << (pri_word[0] ? cmb_pkg::PDW : 0);
      end
      cmb_pkg::CMB_SZ_LONG: begin
        lane_mask = 32'hFFFFFFFF;
      end
      default: begin
        lane_mask = '0;
      end
    endcase
  end
  // ---------------------------------------------------------------
  // program memory
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (bus.prog_wr) begin
      prog_mem[prog_idx] <= bus.pri_write_bus[cmb_pkg::PDW-1:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.prog_read_bus <= '0;
    end else if (bus.prog_rd) begin
      bus.prog_read_bus <= prog_mem[prog_idx];
    end
  end
  // ---------------------------------------------------------------
  // data memory: primary 32-bit port, secondary 16-bit read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (bus.pri_wr && !pri_is_periph) begin
      data_mem[pri_word[cmb_pkg::DMEM_AW-1:1]] <=
        (data_mem[pri_word[cmb_pkg::DMEM_AW-1:1]] & ~lane_mask) | (lane_data & lane_mask);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.pri_read_bus <= '0;
    end else if (bus.pri_rd) begin
      if (pri_is_periph) begin
        bus.pri_read_bus <= {{(cmb_pkg::XDW-cmb_pkg::PRW){1'b0}},
          (periph_idx == cmb_pkg::FLASH_STAT_IDX) ? flash_stat_reg
                                                  : periph_reg[periph_idx]};
      end else begin
        bus.pri_read_bus <= data_mem[pri_word[cmb_pkg::DMEM_AW-1:1]];
      end
    end
  end
  // separate read port so the secondary never waits on the primary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.secondary_read_bus <= '0;
    end else if (bus.sec_rd) begin
      bus.secondary_read_bus <= sec_word[0]
        ? data_mem[sec_word[cmb_pkg::DMEM_AW-1:1]][cmb_pkg::XDW-1:cmb_pkg::PDW]
        : data_mem[sec_word[cmb_pkg::DMEM_AW-1:1]][cmb_pkg::PDW-1:0];
    end
  end
  // ---------------------------------------------------------------
  // peripheral registers and flash control
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cmb_pkg::PERIPH_REGS; i++) begin
        periph_reg[i] <= '0;
      end
      flash_cmd_strobe <= 1'b0;
    end else begin
      flash_cmd_strobe <= 1'b0;
      if (bus.pri_wr && pri_is_periph) begin
        periph_reg[periph_idx] <= bus.pri_write_bus[cmb_pkg::PRW-1:0];
        flash_cmd_strobe <= (periph_idx == cmb_pkg::FLASH_CMD_IDX);
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_stat_reg <= cmb_pkg::FLASH_STAT_RST;
    end else begin
      flash_stat_reg <= flash_status;
    end
  end
  assign flash_cmd = periph_reg[cmb_pkg::FLASH_CMD_IDX];
endmodule : cmb_mem_end
`default_nettype wire

// >>> dv/cmb_assertions.sv
/*
  Checker on the bus that joins the core end and the memory end.
  Assumes the bench instantiates it beside that bus, on the shared clock.
*/
`default_nettype none
module cmb_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [20:0] prog_address_bus,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic [15:0] prog_read_bus,
  input wire logic [23:0] primary_data_address_bus,
  input wire logic pri_rd,
  input wire logic pri_wr,
  input wire cmb_pkg::cmb_size_e pri_size,
  input wire logic [31:0] pri_write_bus,
  input wire logic [31:0] pri_read_bus,
  input wire logic [23:0] secondary_data_address_bus,
  input wire logic sec_rd,
  input wire logic [15:0] secondary_read_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // read after write, one cycle apart
  // ----------------------------------------------------------------
  sequence s_long_wr;
    pri_wr && pri_size == cmb_pkg::CMB_SZ_LONG;
  endsequence
  sequence s_long_rd;
    pri_rd && !pri_wr && pri_size == cmb_pkg::CMB_SZ_LONG;
  endsequence
  property p_prog;
    logic [20:0] a;
    logic [15:0] d;
    (prog_wr, a = prog_address_bus, d = pri_write_bus[15:0]) ##1
      (prog_rd && !prog_wr && prog_address_bus == a) |=> prog_read_bus == d;
  endproperty
  property p_long;
    logic [23:0] a;
    logic [31:0] d;
    (s_long_wr, a = primary_data_address_bus, d = pri_write_bus) ##1
      (s_long_rd ##0 primary_data_address_bus == a) |=> pri_read_bus == d;
  endproperty
  // the secondary half is picked by address bit 0
  property p_sec(bit dual);
    logic [23:0] a;
    logic [31:0] d;
    (s_long_wr, a = primary_data_address_bus, d = pri_write_bus) ##1
      (sec_rd && !pri_wr && (pri_rd == dual) && secondary_data_address_bus[23:1] == a[23:1]
      && (!dual || primary_data_address_bus == a)) |=> secondary_read_bus
      == ($past(secondary_data_address_bus[0]) ? d[31:16] : d[15:0]) && (!dual || pri_read_bus == d);
  endproperty
  property p_byte;
    logic [23:0] a;
    logic [7:0] d;
    (pri_wr && pri_size == cmb_pkg::CMB_SZ_BYTE, a = primary_data_address_bus,
      d = pri_write_bus[7:0]) ##1 (sec_rd && !pri_wr && secondary_data_address_bus == a)
      |=> secondary_read_bus[7:0] == d;
  endproperty
  chk_byte_msb_low: assert property ((pri_rd || pri_wr) && pri_size == cmb_pkg::CMB_SZ_BYTE
    |-> !primary_data_address_bus[23]) else $error("byte access with address msb set");
  chk_prog_low_half: assert property (p_prog)
    else $error("program read after write mismatch");
  chk_prog_repeat_read: assert property (prog_rd && !prog_wr ##1 prog_rd && !prog_wr
    && $stable(prog_address_bus) |=> $stable(prog_read_bus)) else $error("program reread differs");
  chk_long_rd_wr: assert property (p_long)
    else $error("primary long read after write mismatch");
  chk_sec_word_half: assert property (p_sec(1'b0))
    else $error("secondary word read mismatch");
  chk_dual_same_cycle: assert property (p_sec(1'b1))
    else $error("dual read in one cycle mismatch");
  chk_byte_low_lane: assert property (p_byte)
    else $error("byte write read back mismatch");
  chk_periph_zero_ext: assert property (pri_rd && (primary_data_address_bus
    & cmb_pkg::PERIPH_MASK) == cmb_pkg::PERIPH_BASE |=> pri_read_bus[31:16] == 16'h0000)
    else $error("peripheral read upper half not zero");
endmodule // cmb_checker
`default_nettype wire

// >>> dv/test_core_memory_bus_interface.sv
/*
  Bench driving the core end requests against the memory end.
  Assumes the fixed three-cycle read answer of the core end.
*/
`default_nettype none
module test_core_memory_bus_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, req_prog_rd, req_prog_wr, req_pri_rd, req_pri_wr, req_sec_rd;
  logic [20:0] req_prog_addr;
  logic [23:0] req_pri_addr, req_sec_addr;
  logic [31:0] req_pri_wdata, pri_rdata;
  cmb_pkg::cmb_size_e req_pri_size;
  logic [15:0] flash_status, prog_rdata, sec_rdata, flash_cmd;
  logic prog_rvalid, pri_rvalid, sec_rvalid, flash_cmd_strobe;
  int mismatches, checked, cycles, strobes;
  wire [31:0] valids = {29'h0, prog_rvalid, pri_rvalid, sec_rvalid};
  cmb_if i_cmb_if ();
  cmb_core_end i_cmb_core_end (.clk, .rst, .bus(i_cmb_if.core), .req_prog_rd, .req_prog_wr,
    .req_prog_addr, .req_pri_rd, .req_pri_wr, .req_pri_size, .req_pri_addr, .req_pri_wdata,
    .req_sec_rd, .req_sec_addr, .prog_rdata, .prog_rvalid, .pri_rdata, .pri_rvalid,
    .sec_rdata, .sec_rvalid);
  cmb_mem_end i_cmb_mem_end (.clk, .rst, .bus(i_cmb_if.mem), .flash_cmd, .flash_cmd_strobe,
    .flash_status);
  cmb_checker i_cmb_checker (.clk, .rst, .prog_address_bus(i_cmb_if.prog_address_bus),
    .prog_rd(i_cmb_if.prog_rd), .prog_wr(i_cmb_if.prog_wr),
    .prog_read_bus(i_cmb_if.prog_read_bus),
    .primary_data_address_bus(i_cmb_if.primary_data_address_bus),
    .pri_rd(i_cmb_if.pri_rd), .pri_wr(i_cmb_if.pri_wr), .pri_size(i_cmb_if.pri_size),
    .pri_write_bus(i_cmb_if.pri_write_bus), .pri_read_bus(i_cmb_if.pri_read_bus),
    .secondary_data_address_bus(i_cmb_if.secondary_data_address_bus),
    .sec_rd(i_cmb_if.sec_rd), .secondary_read_bus(i_cmb_if.secondary_read_bus));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // drop all strobes, then wait out the fixed answer latency
  task automatic issue;
    @(posedge clk);
    req_prog_rd <= 1'b0;
    req_prog_wr <= 1'b0;
    req_pri_rd <= 1'b0;
    req_pri_wr <= 1'b0;
    req_sec_rd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_prog;
    @(posedge clk);
    req_prog_addr <= 21'h100123;
    req_pri_wdata <= 32'hABCD1234;
    req_prog_wr <= 1'b1;
    @(posedge clk);
    req_prog_wr <= 1'b0;
    req_prog_rd <= 1'b1;
    @(posedge clk);
    issue;
    chk("prog_rdata", 32'h00001234, {16'h0000, prog_rdata});
    chk("valids", 32'h00000004, valids);
    $display("program test done");
  endtask
  task automatic t_pri;
    @(posedge clk);
    req_pri_size <= cmb_pkg::CMB_SZ_LONG;
    req_pri_addr <= 24'h000010;
    req_pri_wdata <= 32'hCAFEF00D;
    req_pri_wr <= 1'b1;
    @(posedge clk);
    req_pri_wr <= 1'b0;
    req_pri_rd <= 1'b1;
    req_sec_addr <= 24'h000011;
    req_sec_rd <= 1'b1;
    issue;
    chk("pri_rdata", 32'hCAFEF00D, pri_rdata);
    chk("sec_rdata", 32'h0000CAFE, {16'h0000, sec_rdata});
    chk("valids", 32'h00000003, valids);
    @(posedge clk);
    req_pri_addr <= 24'h000020;
    req_pri_wdata <= 32'h5A5A0FF0;
    req_pri_wr <= 1'b1;
    @(posedge clk);
    req_pri_wr <= 1'b0;
    req_sec_addr <= 24'h000020;
    req_sec_rd <= 1'b1;
    issue;
    chk("sec_rdata", 32'h00000FF0, {16'h0000, sec_rdata});
    chk("valids", 32'h00000001, valids);
    $display("dual read test done");
  endtask
  task automatic t_byte;
    @(posedge clk);
    req_pri_size <= cmb_pkg::CMB_SZ_BYTE;
    req_pri_addr <= 24'h800011;
    req_pri_wdata <= 32'h00000077;
    req_pri_wr <= 1'b1;
    @(posedge clk);
    req_pri_wr <= 1'b0;
    req_sec_addr <= 24'h000011;
    req_sec_rd <= 1'b1;
    issue;
    chk("sec_rdata", 32'h0000CA77, {16'h0000, sec_rdata});
    @(posedge clk);
    req_sec_addr <= 24'h000010;
    req_sec_rd <= 1'b1;
    issue;
    chk("sec_rdata", 32'h0000F00D, {16'h0000, sec_rdata});
    $display("byte test done");
  endtask
  task automatic t_periph;
    @(posedge clk);
    flash_status <= 16'hA5C3;
    req_pri_size <= cmb_pkg::CMB_SZ_WORD;
    req_pri_addr <= 24'hFFF000;
    req_pri_wdata <= 32'h00001234;
    req_pri_wr <= 1'b1;
    @(posedge clk);
    req_pri_wr <= 1'b0;
    req_pri_addr <= 24'hFFF001;
    req_pri_rd <= 1'b1;
    issue;
    chk("pri_rdata", 32'h0000A5C3, pri_rdata);
    chk("valids", 32'h00000002, valids);
    chk("flash_cmd", 32'h00001234, {16'h0000, flash_cmd});
    chk("strobes", 32'h00000001, strobes);
    $display("peripheral test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cycles++;
    if (flash_cmd_strobe === 1'b1) strobes++;
    if (cycles == 1000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    {rst, req_prog_rd, req_prog_wr, req_pri_rd, req_pri_wr, req_sec_rd} = 6'h20;
    {req_prog_addr, req_pri_addr, req_sec_addr, req_pri_wdata, flash_status} = '0;
    req_pri_size = cmb_pkg::CMB_SZ_WORD;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_prog;
    t_pri;
    t_byte;
    t_periph;
    report_and_stop;
  end
endmodule // test_core_memory_bus_interface
`default_nettype wire
